// ### nvm_spi_pkg.sv
package nvm_spi_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_IDENTITY_READ = 8'h9f;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_SLEEP = 8'hb9;

  // ----------------------------------------------------------------
  // Array geometry and protection
  // ----------------------------------------------------------------
  localparam int MEM_ADDR_W = 18;
  localparam int MEM_WORDS = 262144;
  localparam logic [17:0] PROT_QUARTER_BASE = 18'h30000;
  localparam logic [17:0] PROT_HALF_BASE = 18'h20000;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int SR_TOP = 7;
  localparam int SR_NV_LO = 2;
  localparam int SR_SPE = 7;
  localparam int SR_BP_HI = 3;
  localparam int SR_BP_LO = 2;
  localparam logic [5:0] SR_NV_RESET = 6'h00;
  localparam logic SR_ZERO_BIT = 1'b0;

  // ----------------------------------------------------------------
  // Bit counts within a command phase (last index of each phase)
  // ----------------------------------------------------------------
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] ID_LAST = 5'h1f;

  // ----------------------------------------------------------------
  // Sleep recovery timing
  // ----------------------------------------------------------------
  localparam int SLEEP_WAKE_TIME_US = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_CYCLES = (SLEEP_WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 17;

  // ----------------------------------------------------------------
  // Command sequencer and power states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OPCODE = 4'h0,
    ST_ADDR = 4'h1,
    ST_DUMMY = 4'h2,
    ST_RDATA = 4'h3,
    ST_WDATA = 4'h4,
    ST_SREAD = 4'h5,
    ST_SWRITE = 4'h6,
    ST_ID = 4'h7,
    ST_IGNORE = 4'h8
  } seq_state_e;

  typedef enum logic [1:0] {
    PW_AWAKE = 2'h0,
    PW_ASLEEP = 2'h1,
    PW_WAKING = 2'h2
  } power_state_e;

endpackage

// ### spi_cmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module spi_cmd_monitor #(
  parameter int WAKE_CYCLES_P = 20
) (
  // System side
  input wire logic clock,
  input wire logic rst,
  // Link lines
  input wire logic sck,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic hold_n,
  // Power state
  input wire logic asleep,
  input wire logic waking
);
  int wake_cnt_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Length of the running recovery, judged when it ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_cnt_q <= 0;
    end else if (waking) begin
      wake_cnt_q <= wake_cnt_q + 1;
    end else begin
      wake_cnt_q <= 0;
    end
  end

  // ------
  // Serial output
  // ------
  property p_idle_float; cs_n |-> so_oe_n; endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("so driven while deselected");
  property p_hold_float; !hold_n && !cs_n |-> so_oe_n; endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("so driven during hold");
  property p_sleep_float; asleep || waking |-> so_oe_n; endproperty
  a_sleep_float: assert property (p_sleep_float)
    else $error("so driven while asleep");
  // Clock held high across two samples: no falling edge, so no change
  property p_so_fall_only;
    !cs_n && $past(!cs_n) && sck && $past(sck) |-> $stable(so);
  endproperty
  a_so_fall_only: assert property (p_so_fall_only)
    else $error("so changed without a falling clock");

  // ------
  // Power states
  // ------
  property p_exclusive; !(asleep && waking); endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("asleep and waking together");
  property p_sleep_deselect; $rose(asleep) |-> cs_n && $past(cs_n);
  endproperty
  a_sleep_deselect: assert property (p_sleep_deselect)
    else $error("sleep entered while selected");
  property p_wake_start; asleep && $fell(cs_n) |-> ##[1:8] waking;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("select fall did not start recovery");
  property p_wake_path; $fell(asleep) |-> ##[0:1] waking; endproperty
  a_wake_path: assert property (p_wake_path)
    else $error("sleep left without recovery");
  property p_wake_len;
    $fell(waking) |-> !asleep && wake_cnt_q >= WAKE_CYCLES_P - 1
      && wake_cnt_q <= WAKE_CYCLES_P + 1;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("recovery length wrong");

  c_sleep: cover property ($rose(asleep));
  c_wake: cover property ($fell(waking));
  c_hold: cover property (!hold_n && !cs_n);
  c_drive: cover property ($fell(so_oe_n));
endmodule

bind spi_nonvolatile_memory_cmd spi_cmd_monitor #(
  .WAKE_CYCLES_P(WAKE_CYCLES_P)
) u_monitor (
  .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .so(so),
  .so_oe_n(so_oe_n), .hold_n(hold_n), .asleep(asleep), .waking(waking)
);

`default_nettype wire

// ### spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  // Lines toward the device
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  // Lines from the device
  input wire logic so,
  input wire logic so_oe_n
);
  logic oe_in_hold;

  // Clock parked low outside frames (mode 0)
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    oe_in_hold = 1'b0;
  end

  // Odd offset keeps link edges off the system clock grid
  task automatic start();
    #40.7 cs_n = 1'b0;
  endtask

  // Floating output reads as unknown, so it never passes as data
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = so_oe_n ? 1'bx : so;
      #40 sck = 1'b0;
    end
  endtask

  // Data line flipped after release, never left at the last bit
  task automatic stop();
    #40 cs_n = 1'b1;
    si = ~si;
    #80;
  endtask

  // Hold entered and left with the clock low; junk clocked meanwhile
  task automatic pause(input int n, input logic abort);
    // Let the last falling edge land before hold gates it
    #20 hold_n = 1'b0;
    repeat (n) begin
      #40 sck = 1'b1;
      si = ~si;
      #40 sck = 1'b0;
    end
    oe_in_hold = so_oe_n;
    if (abort) begin
      cs_n = 1'b1;
    end
    #40 hold_n = 1'b1;
    #80;
  endtask
endmodule

`default_nettype wire

// ### spi_nonvolatile_memory_cmd.sv
// Operation
// - Each frame opens with an 8-bit command; only nine codes exist.
// - Chip select rising mid-command discards it, nothing executes.
// - Command 0x06 sets the write latch, needed before any write.
// - Command 0x04 clears the write latch, blocking all writes.
// - Command 0x05 streams the status byte repeatedly on falling edges.
// - Command 0x01 loads status bits; bit 1 and bit 0 ignored.
// - Command 0x03 takes 24 address bits, upper six ignored, then reads.
// - Each further byte of clocks reads the next address, wrapping.
// - Command 0x02 takes address then data, storing each full byte.
// - Writes auto-increment and wrap until chip select rises.
// - Command 0x0b reads like 0x03 after eight dummy bits.
// - Command 0x9f shifts out 32 identity bits, maker code first.
// - After 32 identity bits the last bit stays on the output.
// - Command 0xb9 sleeps at chip select rise unless clocked further.
// - Asleep, clock and data input are ignored and output floats.
// - Chip select falling wakes the part within 400 us.
// - Two protect bits guard none, upper quarter, upper half or all.
// - Writes need the latch; status write also needs pin high or bit 7 clear.
// - Hold low pauses the command and floats the output.
// - Chip select rising in hold aborts; latch keeps earlier value.
// - Input sampled on rising clock, output changed on falling clock.
// - Latch clears at reset and clear command, not after writes.
`timescale 1ns/1ps
`default_nettype none

module spi_nonvolatile_memory_cmd
  import nvm_spi_pkg::*;
#(
  parameter int WAKE_CYCLES_P = nvm_spi_pkg::WAKE_CYCLES,
  // Identity word, arbitrary neutral value
  parameter logic [31:0] IDENTITY_WORD = 32'h5a7f0102
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic hold_n,
  input wire logic wp_n,
  // Power state
  output logic asleep,
  output logic waking
);
  import nvm_spi_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_e state_q;
  power_state_e pw_q;
  logic frame_rst;
  logic blocked_q;
  logic [4:0] cnt_q;
  logic [7:0] op_q;
  logic [7:0] shift_q;
  logic [7:0] rx_byte;
  logic [MEM_ADDR_W-1:0] addr_q;
  logic [7:0] mem_q [MEM_WORDS];
  logic wel_q;
  logic [SR_TOP:SR_NV_LO] sr_nv_q;
  logic [7:0] status_byte;
  logic wp_s1_q;
  logic wp_s2_q;
  logic byte_done;
  logic op_done;
  logic wr_commit;
  logic sr_commit;
  logic sleep_live_q;
  logic sleep_tgl_q;
  logic so_q;
  logic reading;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_d_q;
  logic live_s1_q;
  logic live_s2_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_ack_q;
  logic cs_rise;
  logic cs_fall;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // First state after a complete command byte
  function automatic seq_state_e decode_op(input logic [7:0] opc);
    seq_state_e st;
    case (opc)
      OP_STATUS_READ: st = ST_SREAD;
      OP_STATUS_WRITE: st = ST_SWRITE;
      OP_READ: st = ST_ADDR;
      OP_WRITE: st = ST_ADDR;
      OP_FAST_READ: st = ST_ADDR;
      OP_IDENTITY_READ: st = ST_ID;
      // Latch, sleep and unknown codes carry no payload
      default: st = ST_IGNORE;
    endcase
    return st;
  endfunction

  // Whether an array address lies in the protected range
  function automatic logic addr_protected(
    input logic [MEM_ADDR_W-1:0] a,
    input logic [1:0] bp
  );
    logic p;
    case (bp)
      BP_NONE: p = 1'b0;
      BP_QUARTER: p = (a >= PROT_QUARTER_BASE);
      BP_HALF: p = (a >= PROT_HALF_BASE);
      BP_ALL: p = 1'b1;
      default: p = 1'b1;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  // Deselect or a blocked link resets all per-frame state at once, so
  // a partial command is simply forgotten. blocked_q is a register of
  // the system domain that only changes while no clock edges are legal.
  assign frame_rst = rst | cs_n | blocked_q;

  // Hold is not synchronised: it gates edges, and the host releases it
  // at the clock level it entered with, so no half edge slips through.
  assign byte_done = hold_n && (cnt_q == BYTE_LAST);
  assign op_done = (state_q == ST_OPCODE) && byte_done;
  assign rx_byte = {shift_q[6:0], si};

  assign status_byte = {sr_nv_q, wel_q, SR_ZERO_BIT};

  assign wr_commit = (state_q == ST_WDATA) && byte_done && wel_q &&
                     !addr_protected(addr_q, sr_nv_q[SR_BP_HI:SR_BP_LO]);

  assign sr_commit = (state_q == ST_SWRITE) && byte_done && wel_q &&
                     !(sr_nv_q[SR_SPE] && !wp_s2_q);

  // ----------------------------------------------------------------
  // Command sequencer (link clock, rising edge)
  // ----------------------------------------------------------------
  // Bits are counted per phase; hold freezes everything in place.
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      state_q <= ST_OPCODE;
      cnt_q <= 5'h00;
      op_q <= 8'h00;
    end else if (hold_n) begin
      case (state_q)
        ST_OPCODE: begin
          if (cnt_q == BYTE_LAST) begin
            cnt_q <= 5'h00;
            op_q <= rx_byte;
            state_q <= decode_op(rx_byte);
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_ADDR: begin
          if (cnt_q == ADDR_LAST) begin
            cnt_q <= 5'h00;
            if (op_q == OP_FAST_READ) begin
              state_q <= ST_DUMMY;
            end else if (op_q == OP_WRITE) begin
              state_q <= ST_WDATA;
            end else begin
              state_q <= ST_RDATA;
            end
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_DUMMY: begin
          if (cnt_q == BYTE_LAST) begin
            cnt_q <= 5'h00;
            state_q <= ST_RDATA;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_SWRITE: begin
          if (cnt_q == BYTE_LAST) begin
            state_q <= ST_IGNORE;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_RDATA, ST_WDATA, ST_SREAD: begin
          // Endless byte stream until deselect
          if (cnt_q == BYTE_LAST) begin
            cnt_q <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_ID: begin
          // Saturate so the last identity bit keeps being driven
          if (cnt_q != ID_LAST) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_IGNORE: begin
          cnt_q <= cnt_q;
        end
        default: begin
          state_q <= ST_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input shifter and address counter
  // ----------------------------------------------------------------
  // Address shifts in whole; only the low bits survive, so the upper
  // six of the 24 fall off the top.
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      shift_q <= 8'h00;
      addr_q <= '0;
    end else if (hold_n) begin
      shift_q <= rx_byte;
      if (state_q == ST_ADDR) begin
        addr_q <= {addr_q[MEM_ADDR_W-2:0], si};
      end else if ((state_q == ST_RDATA || state_q == ST_WDATA) &&
                   cnt_q == BYTE_LAST) begin
        // Natural wrap of the counter rolls the top address to zero
        addr_q <= addr_q + 18'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------
  // Changes only once a command byte is complete; an abort in hold
  // before that leaves the latch untouched. Writes never clear it.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (op_done && rx_byte == OP_LATCH_SET) begin
      wel_q <= 1'b1;
    end else if (op_done && rx_byte == OP_LATCH_CLEAR) begin
      wel_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write-protect pin synchroniser
  // ----------------------------------------------------------------
  // Pin is steady from before the command, so sixteen edges are ample.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile status bits
  // ----------------------------------------------------------------
  // Latch bit and fixed zero bit are not stored here at all.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      sr_nv_q <= SR_NV_RESET;
    end else if (sr_commit) begin
      sr_nv_q <= rx_byte[SR_TOP:SR_NV_LO];
    end
  end

  // ----------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------
  // Byte lands on its eighth rising edge; no deselect needed.
  always_ff @(posedge sck) begin
    if (wr_commit) begin
      mem_q[addr_q] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Sleep request
  // ----------------------------------------------------------------
  // Live flag drops on any further rising edge, cancelling the request;
  // the toggle marks each new request so one is consumed only once.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      sleep_live_q <= 1'b0;
      sleep_tgl_q <= 1'b0;
    end else if (op_done && rx_byte == OP_SLEEP) begin
      sleep_live_q <= 1'b1;
      sleep_tgl_q <= ~sleep_tgl_q;
    end else begin
      sleep_live_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial output (link clock, falling edge)
  // ----------------------------------------------------------------
  // Bit index comes from the rising-edge counter, MSB first.
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
    end else if (hold_n) begin
      case (state_q)
        ST_RDATA: so_q <= mem_q[addr_q][3'(BYTE_LAST - cnt_q)];
        ST_SREAD: so_q <= status_byte[3'(BYTE_LAST - cnt_q)];
        ST_ID: so_q <= IDENTITY_WORD[ID_LAST - cnt_q];
        default: so_q <= so_q;
      endcase
    end
  end

  assign reading = (state_q == ST_RDATA) || (state_q == ST_SREAD) ||
                   (state_q == ST_ID);
  assign so = so_q;
  // Floats when deselected, asleep, in hold, or not sending
  assign so_oe_n = !(reading && hold_n && !cs_n &&
                     !blocked_q);

  // ----------------------------------------------------------------
  // System domain synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_d_q <= 1'b1;
      live_s1_q <= 1'b0;
      live_s2_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_d_q <= cs_s2_q;
      live_s1_q <= sleep_live_q;
      live_s2_q <= live_s1_q;
      tgl_s1_q <= sleep_tgl_q;
      tgl_s2_q <= tgl_s1_q;
    end
  end

  assign cs_rise = cs_s2_q && !cs_d_q;
  assign cs_fall = !cs_s2_q && cs_d_q;

  // ----------------------------------------------------------------
  // Sleep request acknowledge
  // ----------------------------------------------------------------
  // Every deselect consumes the pending toggle, taken or cancelled.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tgl_ack_q <= 1'b0;
    end else if (cs_rise) begin
      tgl_ack_q <= tgl_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  // Recovery is timed here because the link clock may stand still.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pw_q <= PW_AWAKE;
      wake_cnt_q <= '0;
    end else begin
      case (pw_q)
        PW_AWAKE: begin
          if (cs_rise && live_s2_q && (tgl_s2_q != tgl_ack_q)) begin
            pw_q <= PW_ASLEEP;
          end
        end
        PW_ASLEEP: begin
          wake_cnt_q <= '0;
          if (cs_fall) begin
            pw_q <= PW_WAKING;
          end
        end
        PW_WAKING: begin
          // Chip select may rise meanwhile; counting carries on
          if (wake_cnt_q == WAKE_CNT_W'(WAKE_CYCLES_P - 1)) begin
            pw_q <= PW_AWAKE;
          end else begin
            wake_cnt_q <= wake_cnt_q + 17'h00001;
          end
        end
        default: begin
          pw_q <= PW_AWAKE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link block and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blocked_q <= 1'b0;
      asleep <= 1'b0;
      waking <= 1'b0;
    end else begin
      blocked_q <= (pw_q != PW_AWAKE) ||
                   (cs_rise && live_s2_q &&
                    (tgl_s2_q != tgl_ack_q));
      asleep <= (pw_q == PW_ASLEEP);
      waking <= (pw_q == PW_WAKING);
    end
  end

endmodule

`default_nettype wire

// ### test_spi_nonvolatile_memory_cmd.sv
`timescale 1ns/1ps
`default_nettype none

module test_spi_nonvolatile_memory_cmd;
  import nvm_spi_pkg::*;
  localparam int WAKE = 20;
  localparam int LIMIT = 80000;
  // Identity value arbitrary
  localparam logic [31:0] ID_WORD = 32'h3c96e5a1;
  logic clock = 1'b0;
  logic rst, sck, cs_n, si, so, so_oe_n, hold_n, wp_n, asleep, waking;
  logic [7:0] junk;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;

  spi_nonvolatile_memory_cmd #(.WAKE_CYCLES_P(WAKE),
    .IDENTITY_WORD(ID_WORD)) dut (
    .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .hold_n(hold_n), .wp_n(wp_n), .asleep(asleep),
    .waking(waking));
  spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so(so), .so_oe_n(so_oe_n));

  always #2 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      test_done();
    end
  end

  // ------
  // Helpers
  // ------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tx8(input logic [7:0] b);
    host.shift(b, 8, junk);
  endtask
  task automatic rx8(output logic [7:0] b);
    host.shift(8'hff, 8, b);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.start();
    tx8(op);
    host.stop();
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    host.start();
    tx8(op);
    tx8(a[23:16]);
    tx8(a[15:8]);
    tx8(a[7:0]);
  endtask
  task automatic sr_exp(input logic [7:0] e);
    logic [7:0] r;
    host.start();
    tx8(OP_STATUS_READ);
    rx8(r);
    check("status", r, e);
    rx8(r);
    check("status again", r, e);
    host.stop();
  endtask
  task automatic sw(input logic [7:0] v);
    hdr(OP_STATUS_WRITE, {v, 16'h0000});
    host.stop();
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    hdr(OP_WRITE, a);
    tx8(d);
    host.stop();
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    logic [7:0] r;
    hdr(OP_READ, a);
    rx8(r);
    check("array", r, e);
    host.stop();
  endtask
  task automatic set_wp(input logic v);
    @(posedge clock);
    #1 wp_n = v;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_write_read();
    logic [7:0] r;
    sr_exp(8'h00);
    cmd(OP_LATCH_SET);
    sr_exp(8'h02);
    hdr(OP_WRITE, 24'hfc0010);
    tx8(8'h3c);
    tx8(8'hc3);
    host.stop();
    sr_exp(8'h02);
    hdr(OP_READ, 24'h000010);
    rx8(r);
    check("read first", r, 8'h3c);
    rx8(r);
    check("read next", r, 8'hc3);
    host.stop();
    cmd(OP_LATCH_CLEAR);
    wr(24'h000010, 8'h55);
    rd(24'h000010, 8'h3c);
  endtask
  task automatic t_wrap();
    logic [7:0] r;
    cmd(OP_LATCH_SET);
    hdr(OP_WRITE, 24'h03ffff);
    tx8(8'h11);
    tx8(8'h22);
    host.stop();
    rd(24'h000000, 8'h22);
    hdr(OP_READ, 24'h03ffff);
    rx8(r);
    rx8(r);
    check("read wrap", r, 8'h22);
    host.stop();
    hdr(OP_FAST_READ, 24'h03ffff);
    tx8(8'h00);
    rx8(r);
    check("fast read", r, 8'h11);
    host.stop();
  endtask
  task automatic t_identity();
    logic [7:0] r;
    host.start();
    tx8(OP_IDENTITY_READ);
    for (int k = 0; k < 4; k++) begin
      rx8(r);
      check("identity", r, ID_WORD[31 - 8 * k -: 8]);
    end
    rx8(r);
    check("identity tail", r, {8{ID_WORD[0]}});
    host.stop();
  endtask
  task automatic t_protect();
    logic [17:0] a [4] = '{18'h1ffff, 18'h20000, 18'h2ffff, 18'h30000};
    logic [7:0] e [4];
    logic [7:0] d;
    cmd(OP_LATCH_SET);
    for (int bp = 0; bp < 4; bp++) begin
      sw({4'h0, bp[1:0], 2'b11});
      sr_exp({4'h0, bp[1:0], 2'b10});
      d = 8'ha0 | {6'h00, bp[1:0]};
      for (int k = 0; k < 4; k++) begin
        wr({6'h00, a[k]}, d);
        if (!(bp == 3 || (bp == 2 && a[k] >= 18'h20000)
            || (bp == 1 && a[k] >= 18'h30000))) begin
          e[k] = d;
        end
      end
      for (int k = 0; k < 4; k++) begin
        rd({6'h00, a[k]}, e[k]);
      end
    end
    sw(8'h00);
  endtask
  task automatic t_status_lock();
    sw(8'h80);
    sr_exp(8'h82);
    set_wp(1'b0);
    sw(8'h8c);
    sr_exp(8'h82);
    set_wp(1'b1);
    sw(8'h00);
    sr_exp(8'h02);
  endtask
  task automatic t_abort();
    logic [7:0] r, r2;
    host.start();
    host.shift(OP_LATCH_CLEAR, 4, r);
    host.stop();
    sr_exp(8'h02);
    host.start();
    host.shift(OP_LATCH_CLEAR, 4, r);
    host.pause(3, 1'b1);
    sr_exp(8'h02);
    host.start();
    tx8(OP_STATUS_READ);
    host.shift(8'hff, 4, r);
    host.pause(2, 1'b0);
    check("hold float", {7'h00, host.oe_in_hold}, 8'h01);
    host.shift(8'hff, 4, r2);
    check("held status", {r[7:4], r2[7:4]}, 8'h02);
    host.stop();
  endtask
  task automatic t_sleep();
    logic [7:0] r;
    host.start();
    tx8(OP_SLEEP);
    host.shift(8'hff, 1, r);
    host.stop();
    repeat (10) @(posedge clock);
    check("sleep cancelled", {7'h00, asleep}, 8'h00);
    cmd(OP_SLEEP);
    repeat (10) @(posedge clock);
    check("asleep", {7'h00, asleep}, 8'h01);
    check("sleep float", {7'h00, so_oe_n}, 8'h01);
    host.start();
    for (int i = 0; i < 8 && waking !== 1'b1; i++) @(posedge clock);
    check("waking", {7'h00, waking}, 8'h01);
    host.stop();
    for (int i = 0; i < WAKE + 8 && waking !== 1'b0; i++) begin
      @(posedge clock);
    end
    check("awake", {6'h00, asleep, waking}, 8'h00);
    host.start();
    tx8(OP_IDENTITY_READ);
    rx8(r);
    check("after wake", r, ID_WORD[31:24]);
    host.stop();
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    t_write_read();
    t_wrap();
    t_identity();
    t_protect();
    t_status_lock();
    t_abort();
    t_sleep();
    test_done();
  end
endmodule

`default_nettype wire
